// ### eeprom_register_interface.sv
// EEPROM address, data and control registers on the special function register port
`timescale 1ns/10ps
`include "eeprom_regs_defs.svh"
module eeprom_register_interface #(
  parameter int ADDR_W = 8
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_sfr_sector,
  input  wire logic       i_sfr_indirect,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_ee_busy
);
  localparam int DEPTH = 1 << ADDR_W;

  // Refuse address widths that no variant has
  if (ADDR_W < `EE_ADDR_W_MIN || ADDR_W > `EE_ADDR_W_MAX) begin
    $error("eeprom_register_interface: ADDR_W must be 5 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic sel_addr = (i_sfr_sector == `EE_SECTOR_DIRECT)
                        && (i_sfr_addr == `EE_ADDR_OFS);
  wire logic sel_data = (i_sfr_sector == `EE_SECTOR_DIRECT)
                        && (i_sfr_addr == `EE_DATA_OFS);
  wire logic sel_ctrl = i_sfr_indirect && (i_sfr_sector == `EE_SECTOR_CTRL)
                        && (i_sfr_addr == `EE_CTRL_OFS);

  wire logic wr_addr  = i_sfr_wr && sel_addr;
  wire logic wr_data  = i_sfr_wr && sel_data;
  wire logic wr_ctrl  = i_sfr_wr && sel_ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [ADDR_W-1:0]         addr_q;
  eeprom_regs_pkg::ee_byte_t data_q;
  logic                      write_enable_q;
  logic                      wr_q;
  logic                      read_enable_q;
  logic                      rd_q;
  eeprom_regs_pkg::ee_state_t state_q;
  eeprom_regs_pkg::ee_state_t state_d;

  eeprom_mem_if mem ();

  wire logic start_wr = wr_q && write_enable_q && (state_q == eeprom_regs_pkg::ST_IDLE);
  wire logic start_rd = rd_q && read_enable_q && (state_q == eeprom_regs_pkg::ST_IDLE)
                        && !start_wr;
  wire logic done_wr  = state_q == eeprom_regs_pkg::ST_WRITE;
  wire logic done_rd  = state_q == eeprom_regs_pkg::ST_READ;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      addr_q <= ADDR_W'(`EE_ADDR_RST);
    end else if (wr_addr) begin
      addr_q <= i_sfr_wdata[ADDR_W-1:0];
    end
  end

  // A finished read loads the data register ahead of a software write
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      data_q <= `EE_DATA_RST;
    end else if (done_rd) begin
      data_q <= mem.rdata;
    end else if (wr_data) begin
      data_q <= i_sfr_wdata;
    end
  end

  // Start bits only take effect while their enable is set and clear when done
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      {write_enable_q, wr_q, read_enable_q, rd_q} <= `EE_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        write_enable_q <= i_sfr_wdata[`EE_BIT_WRITE_ENABLE];
        read_enable_q  <= i_sfr_wdata[`EE_BIT_READ_ENABLE];
      end
      if (wr_ctrl && i_sfr_wdata[`EE_BIT_WR]) begin
        wr_q <= 1'b1;
      end else if (done_wr || (wr_ctrl && !i_sfr_wdata[`EE_BIT_WR])) begin
        wr_q <= 1'b0;
      end
      if (wr_ctrl && i_sfr_wdata[`EE_BIT_RD]) begin
        rd_q <= 1'b1;
      end else if (done_rd || (wr_ctrl && !i_sfr_wdata[`EE_BIT_RD])) begin
        rd_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      eeprom_regs_pkg::ST_IDLE: begin
        if (start_wr) begin
          state_d = eeprom_regs_pkg::ST_WRITE;
        end else if (start_rd) begin
          state_d = eeprom_regs_pkg::ST_READ;
        end
      end
      eeprom_regs_pkg::ST_WRITE: state_d = eeprom_regs_pkg::ST_IDLE;
      eeprom_regs_pkg::ST_READ:  state_d = eeprom_regs_pkg::ST_IDLE;
      default:                   state_d = eeprom_regs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q <= eeprom_regs_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign mem.we    = start_wr;
  assign mem.re    = start_rd;
  assign mem.addr  = 8'(addr_q);
  assign mem.wdata = data_q;

  eeprom_cell_array #(
    .DEPTH (DEPTH)
  ) u_cells (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .mem       (mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back

  wire logic [7:0] ctrl_view = {4'h0, write_enable_q, wr_q, read_enable_q, rd_q};
  wire logic [7:0] rd_mux    = sel_addr ? 8'(addr_q) :
                               sel_data ? data_q :
                               sel_ctrl ? ctrl_view : 8'h00;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
      o_ee_busy   <= 1'b0;
    end else begin
      o_sfr_rdata <= i_sfr_rd ? rd_mux : 8'h00;
      o_ee_busy   <= (state_d != eeprom_regs_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_write_go;
    wr_q && write_enable_q && state_q == eeprom_regs_pkg::ST_IDLE;
  endsequence

  sequence s_write_end;
    state_q == eeprom_regs_pkg::ST_WRITE ##1 !wr_q;
  endsequence

  property p_direct_data_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      (wr_data && !done_rd) |=> (data_q == $past(i_sfr_wdata));
  endproperty
  a_direct_data_write: assert property (p_direct_data_write)
    else $error("direct data write not stored");

  property p_ctrl_needs_indirect;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_sfr_wr && !i_sfr_indirect && i_sfr_sector && i_sfr_addr == 8'h40)
      |=> (write_enable_q == $past(write_enable_q)) && (read_enable_q == $past(read_enable_q));
  endproperty
  a_ctrl_needs_indirect: assert property (p_ctrl_needs_indirect)
    else $error("control changed by direct access");

  property p_addr_upper_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_sfr_rd && sel_addr) |=> ((o_sfr_rdata >> ADDR_W) == 8'h00);
  endproperty
  a_addr_upper_zero: assert property (p_addr_upper_zero)
    else $error("unimplemented address bits not zero");

  property p_addr_reset;
    @(posedge i_clk_sys) i_reset |=> (addr_q == '0);
  endproperty
  a_addr_reset: assert property (p_addr_reset)
    else $error("address not cleared by reset");

  property p_data_reset;
    @(posedge i_clk_sys) i_reset ##1 !wr_data |=> (data_q == 8'h00) || done_rd || $past(wr_data);
  endproperty
  a_data_reset: assert property (p_data_reset)
    else $error("data not cleared by reset");

  property p_ctrl_upper_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_sfr_rd && sel_ctrl) |=> (o_sfr_rdata[7:4] == 4'h0)
      && (o_sfr_rdata[3] == $past(write_enable_q));
  endproperty
  a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
    else $error("control read-back wrong");

  property p_single_byte_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_write_go |-> mem.we && (mem.wdata == data_q) ##1 s_write_end;
  endproperty
  a_single_byte_write: assert property (p_single_byte_write)
    else $error("write start did not move one byte");

  property p_read_completes;
    @(posedge i_clk_sys) disable iff (i_reset)
      start_rd |=> done_rd ##1 (data_q == $past(mem.rdata)) && !rd_q;
  endproperty
  a_read_completes: assert property (p_read_completes)
    else $error("read did not load the data register");
endmodule

// ### eeprom_regs_defs.svh
// Offsets, bit positions and reset values of the EEPROM register interface
`ifndef EEPROM_REGS_DEFS_SVH
`define EEPROM_REGS_DEFS_SVH

// Sector 0, direct special function register addresses
`define EE_ADDR_OFS      8'h1a
`define EE_DATA_OFS      8'h1b
// Sector 1, indirect only
`define EE_CTRL_OFS      8'h40
`define EE_SECTOR_DIRECT 1'b0
`define EE_SECTOR_CTRL   1'b1

// Control register bit positions
`define EE_BIT_WRITE_ENABLE 3
`define EE_BIT_WR        2
`define EE_BIT_READ_ENABLE  1
`define EE_BIT_RD        0

// Reset values
`define EE_ADDR_RST      8'h00
`define EE_DATA_RST      8'h00
`define EE_CTRL_RST      4'h0

// Variant address width limits
`define EE_ADDR_W_MIN    5
`define EE_ADDR_W_MAX    8

`endif

// ### eeprom_regs_pkg.sv
// Types shared by the EEPROM register interface
package eeprom_regs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } ee_state_t;

  typedef logic [7:0] ee_byte_t;

endpackage

// ### eeprom_mem_if.sv
// Carrier between the register interface and the EEPROM cell array
`timescale 1ns/10ps
interface eeprom_mem_if;
  logic                       we;
  logic                       re;
  eeprom_regs_pkg::ee_byte_t  addr;
  eeprom_regs_pkg::ee_byte_t  wdata;
  eeprom_regs_pkg::ee_byte_t  rdata;

  modport ctrl  (output we, output re, output addr, output wdata, input rdata);
  modport store (input we, input re, input addr, input wdata, output rdata);
endinterface

// ### eeprom_cell_array.sv
// Byte-wide EEPROM cell array, one byte per operation
`timescale 1ns/10ps
module eeprom_cell_array #(
  parameter int DEPTH = 256
) (
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  eeprom_mem_if.store mem
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that are not one of the four array sizes
  if (DEPTH < 32 || DEPTH > 256 || (1 << AW) != DEPTH) begin
    $error("eeprom_cell_array: DEPTH must be 32, 64, 128 or 256");
  end

  eeprom_regs_pkg::ee_byte_t cells [DEPTH];
  wire logic [AW-1:0]        cell_idx = mem.addr[AW-1:0];

  // Cells hold their content through reset
  always_ff @(posedge i_clk_sys) begin
    if (mem.we) begin
      cells[cell_idx] <= mem.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mem.rdata <= 8'h00;
    end else if (mem.re) begin
      mem.rdata <= cells[cell_idx];
    end
  end
endmodule

// ### tb_top.sv
// Self-checking testbench for the EEPROM register interface
`timescale 1ns/10ps
`include "eeprom_regs_defs.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb_top;
  localparam int AW = 5;
  logic       i_clk_sys;
  logic       i_reset;
  logic       i_sfr_sector;
  logic       i_sfr_indirect;
  logic [7:0] i_sfr_addr;
  logic       i_sfr_wr;
  logic       i_sfr_rd;
  logic [7:0] i_sfr_wdata;
  logic [7:0] o_sfr_rdata;
  logic       o_ee_busy;
  int         err_count = 0;
  int         total_checks = 0;

  eeprom_register_interface #(.ADDR_W(AW)) i_eeprom_register_interface (
    .i_clk_sys      (i_clk_sys),
    .i_reset        (i_reset),
    .i_sfr_sector   (i_sfr_sector),
    .i_sfr_indirect (i_sfr_indirect),
    .i_sfr_addr     (i_sfr_addr),
    .i_sfr_wr       (i_sfr_wr),
    .i_sfr_rd       (i_sfr_rd),
    .i_sfr_wdata    (i_sfr_wdata),
    .o_sfr_rdata    (o_sfr_rdata),
    .o_ee_busy      (o_ee_busy)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic sec, input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_sfr_sector = sec;
    i_sfr_indirect = ind;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_clk_sys);
    i_sfr_wr = 1'b0;
  endtask

  // Read data is registered, so it is sampled one cycle after the strobe edge
  task automatic rd(input logic sec, input logic ind, input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    i_sfr_sector = sec;
    i_sfr_indirect = ind;
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_clk_sys);
    i_sfr_rd = 1'b0;
    d = o_sfr_rdata;
  endtask

  // Polls the control register until the start bit clears, bounded
  task automatic wait_clear(input int bitpos);
    logic [7:0] v;
    for (int n = 0; n < 16; n++) begin
      rd(1'b1, 1'b1, `EE_CTRL_OFS, v);
      if (v[bitpos] === 1'b0) return;
    end
    err_count++;
    $display("[FAIL] start bit %0d never cleared", bitpos);
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] v;
    rd(1'b0, 1'b0, `EE_ADDR_OFS, v);
    `CHK("address reset", 8'h00, v)
    rd(1'b0, 1'b0, `EE_DATA_OFS, v);
    `CHK("data reset", 8'h00, v)
    rd(1'b1, 1'b1, `EE_CTRL_OFS, v);
    `CHK("control reset", 8'h00, v)
    `CHK("busy reset", 1'b0, o_ee_busy)
  endtask

  task automatic t_regs();
    logic [7:0] v;
    wr(1'b0, 1'b0, `EE_ADDR_OFS, 8'hff);
    rd(1'b0, 1'b0, `EE_ADDR_OFS, v);
    `CHK("address width", 8'h1f, v)
    wr(1'b0, 1'b1, `EE_ADDR_OFS, 8'h0a);
    rd(1'b0, 1'b0, `EE_ADDR_OFS, v);
    `CHK("address rw", 8'h0a, v)
    wr(1'b0, 1'b0, `EE_DATA_OFS, 8'ha5);
    rd(1'b0, 1'b0, `EE_DATA_OFS, v);
    `CHK("data rw", 8'ha5, v)
    rd(1'b0, 1'b0, 8'h3e, v);
    `CHK("unmapped read", 8'h00, v)
  endtask

  task automatic t_ctrl();
    logic [7:0] v;
    wr(1'b1, 1'b0, `EE_CTRL_OFS, 8'h0a);
    rd(1'b1, 1'b1, `EE_CTRL_OFS, v);
    `CHK("direct control write", 8'h00, v)
    wr(1'b1, 1'b1, `EE_CTRL_OFS, 8'hfa);
    rd(1'b1, 1'b1, `EE_CTRL_OFS, v);
    `CHK("control enables", 8'h0a, v)
    rd(1'b1, 1'b0, `EE_CTRL_OFS, v);
    `CHK("direct control read", 8'h00, v)
    wr(1'b1, 1'b1, `EE_CTRL_OFS, 8'h04);
    @(negedge i_clk_sys);
    `CHK("start without enable busy", 1'b0, o_ee_busy)
    rd(1'b1, 1'b1, `EE_CTRL_OFS, v);
    `CHK("start without enable", 8'h04, v)
    wr(1'b1, 1'b1, `EE_CTRL_OFS, 8'h00);
  endtask

  task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
    wr(1'b0, 1'b0, `EE_ADDR_OFS, a);
    wr(1'b0, 1'b0, `EE_DATA_OFS, d);
    wr(1'b1, 1'b1, `EE_CTRL_OFS, 8'h0c);
    @(negedge i_clk_sys);
    `CHK("busy during write", 1'b1, o_ee_busy)
    wait_clear(`EE_BIT_WR);
    `CHK("busy after write", 1'b0, o_ee_busy)
  endtask

  task automatic ee_read(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    wr(1'b0, 1'b0, `EE_ADDR_OFS, a);
    wr(1'b0, 1'b0, `EE_DATA_OFS, 8'h00);
    wr(1'b1, 1'b1, `EE_CTRL_OFS, 8'h03);
    @(negedge i_clk_sys);
    `CHK("busy during read", 1'b1, o_ee_busy)
    wait_clear(`EE_BIT_RD);
    `CHK("busy after read", 1'b0, o_ee_busy)
    rd(1'b0, 1'b0, `EE_DATA_OFS, v);
    `CHK("array byte", exp, v)
  endtask

  // Upper address bits are dropped, so 0xf3 must alias 0x13 in a 32-byte array
  task automatic t_array();
    ee_write(8'h13, 8'h5c);
    ee_write(8'h1f, 8'ha3);
    ee_write(8'h00, 8'h7e);
    ee_read(8'hf3, 8'h5c);
    ee_read(8'h1f, 8'ha3);
    ee_read(8'h00, 8'h7e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset = 1'b1;
    i_sfr_sector = 1'b0;
    i_sfr_indirect = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_sfr_wdata = 8'h00;
    repeat (16) @(negedge i_clk_sys);
    i_reset = 1'b0;
    t_reset();
    t_regs();
    t_ctrl();
    t_array();
    print_verdict();
  end
endmodule
